// >>> tb/acs_far_model.sv
// analogue core and dma controller seen from the sequencer.
// assumes one go pulse per conversion and acknowledges only held requests.
`timescale 1ns/100ps
`default_nettype none
module acs_far_model #(
   parameter int LAT     = 12,  // conversion time in clocks
   parameter int ACK_LAT = 3    // dma answer delay in clocks
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_go,
   input  wire logic i_dma_req,
   output logic      o_done,
   output logic      o_dma_ack
);
   int cnt;   // conversion cycles left
   int acnt;  // cycles the request has been held
   ////////////////////////////////////////////////////////////////////////////
   // one done per go; a one-cycle edge request never earns an acknowledge
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 0;
         acnt <= 0;
         o_done <= 1'b0;
         o_dma_ack <= 1'b0;
      end else begin
         o_done <= (cnt == 1);
         cnt <= i_go ? LAT : (cnt > 0 ? cnt - 1 : 0);
         acnt <= (i_dma_req && !o_dma_ack) ? acnt + 1 : 0;
         o_dma_ack <= i_dma_req && !o_dma_ack && acnt == ACK_LAT - 1;
      end
   end
endmodule
`default_nettype wire

// >>> tb/acs_seq_checker.sv
// port assertions for the conversion sequencer, bound to every instance.
// assumes control fields change only through register writes.
`timescale 1ns/100ps
`default_nettype none
`include "acs_map.vh"
module acs_seq_checker (
   input wire        i_clk,
   input wire        i_rst,
   input wire [2:0]  i_addr,
   input wire [15:0] i_wdata,
   input wire        i_wr,
   input wire [3:0]  i_src_tick,
   input wire        i_dma_ack,
   input wire        o_dma_req,
   input wire        o_busy,
   input wire        o_sampling,
   input wire        o_conv_go,
   input wire        i_conv_done,
   input wire [3:0]  o_ref_select,
   input wire        o_power_on,
   input wire        o_adc_tick
);
   reg       pulse_q;  // shadow of pulse_sample_select
   reg       sub_q;    // subsystem clock with divide by one
   reg       lvl_q;    // shadow of dma_level_select
   reg [3:0] tick_q;   // adc ticks seen while sampling
   ////////////////////////////////////////////////////////////////////////////
   // shadows follow writes at the same edge as the design registers
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pulse_q <= 1'b0;
         sub_q   <= 1'b0;
         lvl_q   <= 1'b0;
         tick_q  <= 4'h0;
      end else begin
         if (i_wr && i_addr == `ACS_ADDR_CTL0) pulse_q <= i_wdata[7];
         if (i_wr && i_addr == `ACS_ADDR_CTL1) sub_q <= (i_wdata[8:4] == 5'h03);
         if (i_wr && i_addr == `ACS_ADDR_CTL2) lvl_q <= i_wdata[12];
         // saturates so a long sample cannot wrap below six
         if (!o_sampling) tick_q <= 4'h0;
         else if (o_adc_tick && tick_q != 4'hf) tick_q <= tick_q + 4'h1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////////////
   soft_start_a: assert property (
      i_wr && i_addr == `ACS_ADDR_CTL0 && (i_wdata & 16'h0013) == 16'h0013
      && o_power_on && !o_busy |=> ##[0:1] o_sampling)
      else $error("soft start did not begin sampling");
   go_after_sample_a: assert property (
      o_conv_go |-> $past(o_sampling) && !o_sampling ##1 !o_conv_go)
      else $error("conversion pulse outside end of sampling");
   dma_per_conv_a: assert property (
      $rose(o_dma_req) |-> $past(i_conv_done))
      else $error("dma request without a finished conversion");
   dma_edge_pulse_a: assert property (
      o_dma_req && !lvl_q |=> !o_dma_req)
      else $error("edge dma request longer than one cycle");
   ext_sample_min_a: assert property (
      o_conv_go && !pulse_q && !o_ref_select[0] && (!o_ref_select[3] || o_ref_select[2])
      |-> tick_q >= 4'h6)
      else $error("extended unbuffered sample too short");
   subsys_clock_a: assert property (
      sub_q && $past(sub_q) && o_adc_tick
      |-> $past(i_src_tick[3]) || $past(i_src_tick[3], 2))
      else $error("adc tick not from subsystem clock");
   busy_drop_a: assert property (
      $fell(o_busy) |-> $past(i_conv_done) || !$past(o_power_on) || !o_power_on)
      else $error("busy fell without completion");
   level_hold_a: assert property (
      o_dma_req && lvl_q && !i_dma_ack |=> o_dma_req)
      else $error("level dma request dropped before acknowledge");
   level_clear_a: assert property (
      o_dma_req && i_dma_ack |=> !o_dma_req)
      else $error("dma request survived acknowledge");
   cover property (o_conv_go && !pulse_q && !o_ref_select[0]);
   cover property (o_dma_req && lvl_q && i_dma_ack);
   cover property ($fell(o_busy) && !o_power_on);
endmodule
bind acs_sequencer acs_seq_checker u_chk (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
   .i_src_tick, .i_dma_ack, .o_dma_req, .o_busy, .o_sampling, .o_conv_go,
   .i_conv_done, .o_ref_select, .o_power_on, .o_adc_tick);
`default_nettype wire

// >>> tb/tb_acs_sequencer.sv
// self-checking bench: register tasks drive the sequencer against the model.
// assumes the register map header and one 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "acs_map.vh"
module tb_acs_sequencer;
   logic        i_clk, i_rst, i_wr, i_rd;
   logic [2:0]  i_addr, i_timer_trig;
   logic [15:0] i_wdata, rv;
   logic [3:0]  i_src_tick;
   wire  [15:0] o_rdata;
   wire  [3:0]  o_channel, o_ref_select;
   wire         o_dma_req, o_busy, o_sampling, o_conv_go, o_power_on, o_adc_tick;
   wire         ack, done;
   logic        dma_q;
   int          mismatches, comparisons, cycles, dma_n, done_n, ticks, d0, c0, t0;
   acs_sequencer dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_timer_trig, .i_src_tick, .i_dma_ack(ack), .o_dma_req, .o_busy, .o_sampling,
      .o_conv_go, .i_conv_done(done), .o_channel, .o_ref_select, .o_power_on, .o_adc_tick);
   acs_far_model far (.i_clk, .i_rst, .i_go(o_conv_go), .i_dma_req(o_dma_req),
      .o_done(done), .o_dma_ack(ack));
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   // source ticks, event counters and the hang limit
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      i_src_tick <= {cycles[1:0] == 2'h0, cycles[2:0] == 3'h5, cycles[0], 1'b1};
      dma_q <= o_dma_req;
      if (o_dma_req && !dma_q) dma_n <= dma_n + 1;
      if (done) done_n <= done_n + 1;
      if (o_sampling && o_adc_tick) ticks <= ticks + 1;
      if (cycles == 30000) begin
         mismatches = mismatches + 1;
         final_report;
      end
   end
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // polls busy with a bound, then lets the dma cycle land
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         @(posedge i_clk);
         #1 n++;
      end while (o_busy !== 1'b0 && n < 2000);
      chk({15'h0, o_busy}, 16'h0000);
      repeat (2) @(posedge i_clk);
   endtask
   // timer pin pulse, then wait until the sequencer has taken it
   task automatic trig(input int hi);
      int n;
      n = 0;
      @(posedge i_clk);
      i_timer_trig[0] <= 1'b1;
      repeat (hi) @(posedge i_clk);
      i_timer_trig[0] <= 1'b0;
      while (o_busy !== 1'b1 && n < 20) begin
         @(posedge i_clk);
         #1 n++;
      end
   endtask
   task final_report;
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      i_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 3'h0; i_wdata = 16'h0000;
      i_timer_trig = 3'h0; i_src_tick = 4'h0; dma_q = 1'b0;
      mismatches = 0; comparisons = 0; cycles = 0; dma_n = 0; done_n = 0; ticks = 0;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      // reset values of every word, one unmapped word included
      for (int a = 0; a < 6; a++) begin
         rd(3'(a), rv);
         chk(rv, 16'h0000);
      end
      wr(`ACS_ADDR_CTL2, 16'h0421);
      wr(`ACS_ADDR_CTL0, 16'h0012);
      // every sequence mode by soft start; repeats stopped by enable clear
      for (int m = 0; m < 4; m++) begin
         d0 = dma_n;
         c0 = done_n;
         wr(`ACS_ADDR_CTL1, 16'h0030 | 16'(m));
         wr(`ACS_ADDR_CTL0, 16'h0093);
         if (m >= 2) begin
            repeat (80) @(posedge i_clk);
            wr(`ACS_ADDR_CTL0, 16'h0090);
         end
         wait_idle;
         rd(`ACS_ADDR_CTL0, rv);
         chk(rv, m >= 2 ? 16'h0090 : 16'h0092);
         chk(16'(dma_n - d0), 16'(done_n - c0));
         if (m < 2) chk(16'(done_n - c0), m ? 16'h0003 : 16'h0001);
         wr(`ACS_ADDR_CTL0, 16'h0012);
      end
      // level dma request held until the model answers
      wr(`ACS_ADDR_CTL1, 16'h0030);
      wr(`ACS_ADDR_CTL2, 16'h1421);
      d0 = dma_n;
      wr(`ACS_ADDR_CTL0, 16'h0093);
      wait_idle;
      repeat (6) @(posedge i_clk);
      chk({15'h0, o_dma_req}, 16'h0000);
      chk(16'(dma_n - d0), 16'h0001);
      // extended sampling from a short timer pulse, unbuffered then buffered
      for (int r = 0; r < 2; r++) begin
         wr(`ACS_ADDR_CTL2, 16'h0420 | 16'(r));
         wr(`ACS_ADDR_CTL1, 16'h0034);
         wr(`ACS_ADDR_CTL0, 16'h0010);
         wr(`ACS_ADDR_CTL0, 16'h0012);
         t0 = ticks;
         trig(4);
         wait_idle;
         chk({15'h0, (ticks - t0) >= 6}, r ? 16'h0000 : 16'h0001);
      end
      // timer sequence waits between channels on a divided second source
      wr(`ACS_ADDR_CTL2, 16'h0421);
      wr(`ACS_ADDR_CTL1, 16'h0065);
      wr(`ACS_ADDR_CTL0, 16'h0010);
      wr(`ACS_ADDR_CTL0, 16'h0012);
      chk({11'h0, o_power_on, o_ref_select}, 16'h0011);
      c0 = done_n;
      d0 = dma_n;
      for (int k = 0; k < 3; k++) begin
         trig(4);
         wait_idle;
         rd(`ACS_ADDR_STATUS, rv);
         chk(rv, k < 2 ? 16'(k + 3) : 16'h0002);
      end
      chk(16'(done_n - c0), 16'h0003);
      chk(16'(dma_n - d0), 16'h0003);
      // second rise while busy breaks the trigger period on purpose
      wr(`ACS_ADDR_CTL1, 16'h0034);
      wr(`ACS_ADDR_CTL0, 16'h0010);
      wr(`ACS_ADDR_CTL0, 16'h0012);
      trig(4);
      trig(4);
      wait_idle;
      rd(`ACS_ADDR_FLAG2, rv);
      chk(rv, 16'h0001);
      wr(`ACS_ADDR_FLAG2, 16'h0001);
      rd(`ACS_ADDR_FLAG2, rv);
      chk(rv, 16'h0000);
      wr(`ACS_ADDR_CTL0, 16'h0000);
      wr(`ACS_ADDR_CTL0, 16'h0010);
      wr(`ACS_ADDR_CTL0, 16'h0012);
      // power removed while sampling must drop busy at once
      trig(4);
      wr(`ACS_ADDR_CTL0, 16'h0000);
      @(posedge i_clk);
      #1 chk({15'h0, o_busy}, 16'h0000);
      // reset in the middle of a soft sequence
      wr(`ACS_ADDR_CTL1, 16'h0031);
      wr(`ACS_ADDR_CTL0, 16'h0093);
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b1;
      @(posedge i_clk);
      #1 chk({11'h0, o_busy, o_channel}, 16'h0000);
      @(posedge i_clk);
      i_rst <= 1'b0;
      rd(`ACS_ADDR_CTL0, rv);
      chk(rv, 16'h0000);
      final_report;
   end
endmodule
`default_nettype wire

// >>> verilog/acs_map.vh
// register map, field positions, reset values and timing counts of the
// conversion sequencer; included by the sequencer, the checker and the bench, not by the pin synchroniser.
// assumes a 16-bit register port with a 3-bit word address.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// word addresses
`define ACS_ADDR_CTL0      3'h0
`define ACS_ADDR_CTL1      3'h1
`define ACS_ADDR_CTL2      3'h2
`define ACS_ADDR_FLAG2     3'h3
`define ACS_ADDR_STATUS    3'h4

// conv_control_zero fields
`define ACS_SOFT_START     0
`define ACS_ENABLE         1
`define ACS_POWER_ON       4
`define ACS_PULSE_SAMPLE   7
`define ACS_SHT_LSB        8
`define ACS_SHT_MSB        11

// conv_control_one fields
`define ACS_SEQ_LSB        0
`define ACS_SEQ_MSB        1
`define ACS_TRIG_LSB       2
`define ACS_TRIG_MSB       3
`define ACS_CSRC_LSB       4
`define ACS_CSRC_MSB       5
`define ACS_DIV_LSB        6
`define ACS_DIV_MSB        8
`define ACS_BUSY           15

// conv_control_two fields
`define ACS_REF_LSB        0
`define ACS_REF_MSB        3
`define ACS_FIRST_LSB      4
`define ACS_FIRST_MSB      7
`define ACS_LAST_LSB       8
`define ACS_LAST_MSB       11
`define ACS_DMA_LEVEL      12

// second_flag_register fields
`define ACS_TOV_FLAG       0

// reset values
`define ACS_CTL0_RST       16'h0000
`define ACS_CTL1_RST       16'h0000
`define ACS_CTL2_RST       16'h0000

// sequence_mode_field codes
`define ACS_SEQ_SINGLE     2'h0
`define ACS_SEQ_SEQUENCE   2'h1
`define ACS_SEQ_REPEAT     2'h2
`define ACS_SEQ_REP_SEQ    2'h3

// clock source code of the subsystem clock
`define ACS_CSRC_SUBSYS    2'h3

// least extended sample time with an unbuffered reference, in adc clocks
`define ACS_MIN_EXT_SAMPLE 4'h6

`endif

// >>> verilog/acs_pin_sync.v
// three-flop synchroniser with agreement filter for one pin input.
// assumes the pin is asynchronous to i_clk; reports level and rising edge.
`timescale 1ns/100ps
`default_nettype none

module acs_pin_sync (
   input  wire i_clk,
   input  wire i_rst,
   input  wire i_pin,
   output wire o_level,
   output wire o_rise
);

   reg s1_reg;     // metastability catcher, read only by s2
   reg s2_reg;     // second stage
   reg s3_reg;     // third stage
   reg level_reg;  // filtered level
   reg rise_reg;   // one-cycle rising pulse

   ////////////////////////////////////////////////////////////////////////
   // a change counts only once stages two and three agree
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_reg    <= 1'b0;
         s2_reg    <= 1'b0;
         s3_reg    <= 1'b0;
         level_reg <= 1'b0;
         rise_reg  <= 1'b0;
      end else begin
         s1_reg   <= i_pin;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         rise_reg <= 1'b0;
         if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
            rise_reg  <= s3_reg & ~level_reg;
         end
      end
   end

   assign o_level = level_reg;
   assign o_rise  = rise_reg;

endmodule
`default_nettype wire

// >>> verilog/acs_sequencer.v
// conversion sequencer of a 12-bit successive-approximation converter:
// trigger selection, sample timing, channel sequencing, busy, dma request.
// assumes the analogue core answers each o_conv_go with one i_conv_done
// pulse, and that clock-source ticks are one-cycle enables on i_clk.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "acs_map.vh"

module acs_sequencer (
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire [2:0]  i_addr,        // register word address
   input  wire [15:0] i_wdata,       // register write data
   input  wire        i_wr,          // write strobe
   input  wire        i_rd,          // read strobe
   output wire [15:0] o_rdata,       // read data, cycle after i_rd
   input  wire [2:0]  i_timer_trig,  // timer trigger pins
   input  wire [3:0]  i_src_tick,    // clock source ticks, 3 = subsystem
   input  wire        i_dma_ack,     // dma controller acknowledge
   output wire        o_dma_req,     // dma trigger request
   output wire        o_busy,        // conv_busy_flag
   output wire        o_sampling,    // sample switch closed
   output wire        o_conv_go,     // start conversion pulse to core
   input  wire        i_conv_done,   // conversion finished pulse
   output wire [3:0]  o_channel,     // channel being converted
   output wire [3:0]  o_ref_select,  // reference_select to the core
   output wire        o_power_on,    // converter_power_on to the core
   output wire        o_adc_tick     // divided converter clock enable
);

   localparam [1:0] ST_IDLE = 2'h0;  // nothing in progress
   localparam [1:0] ST_WAIT = 2'h1;  // mid sequence, awaiting timer
   localparam [1:0] ST_SAMP = 2'h2;  // sampling
   localparam [1:0] ST_CONV = 2'h3;  // converting

   reg  [15:0] ctl0_reg;             // conv_control_zero
   reg  [15:0] ctl1_reg;             // conv_control_one, bit 15 unused
   reg  [15:0] ctl2_reg;             // conv_control_two
   reg         tov_reg;              // trigger_overflow_flag
   reg  [15:0] rdata_reg;            // read data
   reg  [1:0]  state_reg;            // sequencer state
   reg  [3:0]  chan_reg;             // sequence position
   reg  [3:0]  scnt_reg;             // sample clocks counted
   reg  [2:0]  div_reg;              // divider count
   reg         tick_reg;             // divided clock enable
   reg         go_reg;               // core start pulse
   reg         dma_reg;              // dma trigger state
   wire [2:0]  tmr_level;            // filtered timer levels
   wire [2:0]  tmr_rise;             // timer rising pulses

   // control field views
   wire       soft_start = ctl0_reg[`ACS_SOFT_START];
   wire       enable     = ctl0_reg[`ACS_ENABLE];
   wire       power_on   = ctl0_reg[`ACS_POWER_ON];
   wire       pulse_mode = ctl0_reg[`ACS_PULSE_SAMPLE];
   wire [3:0] sht        = ctl0_reg[`ACS_SHT_MSB:`ACS_SHT_LSB];
   wire [1:0] seq_mode   = ctl1_reg[`ACS_SEQ_MSB:`ACS_SEQ_LSB];
   wire [1:0] trig_src   = ctl1_reg[`ACS_TRIG_MSB:`ACS_TRIG_LSB];
   wire [1:0] clk_src    = ctl1_reg[`ACS_CSRC_MSB:`ACS_CSRC_LSB];
   wire [2:0] divider    = ctl1_reg[`ACS_DIV_MSB:`ACS_DIV_LSB];
   wire [3:0] ref_sel    = ctl2_reg[`ACS_REF_MSB:`ACS_REF_LSB];
   wire [3:0] first_ch   = ctl2_reg[`ACS_FIRST_MSB:`ACS_FIRST_LSB];
   wire [3:0] last_ch    = ctl2_reg[`ACS_LAST_MSB:`ACS_LAST_LSB];
   wire       dma_level  = ctl2_reg[`ACS_DMA_LEVEL];

   ////////////////////////////////////////////////////////////////////////
   // timer trigger pins
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_tmr
         acs_pin_sync u_sync (
            .i_clk   (i_clk),
            .i_rst   (i_rst),
            .i_pin   (i_timer_trig[g]),
            .o_level (tmr_level[g]),
            .o_rise  (tmr_rise[g])
         );
      end
   endgenerate

   // trigger code 0 is the soft start bit, codes 1..3 pick a timer
   wire soft_src  = (trig_src == 2'h0);
   wire [1:0] tix = trig_src - 2'h1;
   wire ext_rise  = ~soft_src & tmr_rise[tix];
   wire ext_level = ~soft_src & tmr_level[tix];
   wire run_ok    = enable & power_on;
   wire start_evt = soft_src ? soft_start : ext_rise;
   wire held      = soft_src ? soft_start : ext_level;
   wire busy      = (state_reg == ST_SAMP) | (state_reg == ST_CONV);

   // only codes 0,2,4,6,12,14 need the long sample; 8 and 10 are spared
   wire buffered  = ref_sel[0] | (ref_sel[3] & ~ref_sel[2]);
   wire ext_min   = buffered | (scnt_reg >= `ACS_MIN_EXT_SAMPLE);
   wire samp_end  = tick_reg & (pulse_mode ? (scnt_reg >= sht)
                                           : (~held & ext_min));
   wire last_pos  = (chan_reg == last_ch);
   wire wr_ctl0   = i_wr & (i_addr == `ACS_ADDR_CTL0);

   ////////////////////////////////////////////////////////////////////////
   // converter clock: source select then divide by divider+1
   wire src_tick = i_src_tick[clk_src];
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         div_reg  <= 3'h0;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= 1'b0;
         if (src_tick) begin
            // divider count carries over a source change; nothing restarts it
            if (div_reg >= divider) begin
               div_reg  <= 3'h0;
               tick_reg <= 1'b1;
            end else begin
               div_reg <= div_reg + 3'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // completion decision for the conversion now finishing
   reg       fin_next;   // sequence ends, busy and start drop
   reg       cont_next;  // go on without waiting for a trigger
   reg [3:0] chan_next;  // next sequence position
   always @* begin
      fin_next  = 1'b0;
      cont_next = 1'b0;
      chan_next = chan_reg;
      case (seq_mode)
         `ACS_SEQ_SINGLE: begin
            fin_next = 1'b1;
         end
         `ACS_SEQ_SEQUENCE: begin
            fin_next  = last_pos;
            chan_next = chan_reg + 4'h1;
            cont_next = soft_src;
         end
         `ACS_SEQ_REPEAT: begin
            fin_next  = ~enable;
            cont_next = soft_src;
         end
         `ACS_SEQ_REP_SEQ: begin
            fin_next  = ~enable;
            chan_next = last_pos ? first_ch : chan_reg + 4'h1;
            cont_next = soft_src;
         end
         default: begin
            fin_next = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer state machine
   wire done_now = (state_reg == ST_CONV) & i_conv_done;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
         chan_reg  <= 4'h0;
         scnt_reg  <= 4'h0;
         go_reg    <= 1'b0;
      end else begin
         go_reg <= 1'b0;
         if (!power_on) begin
            // power removed aborts whatever is in progress
            state_reg <= ST_IDLE;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  scnt_reg <= 4'h0;
                  chan_reg <= first_ch;
                  if (run_ok && start_evt) begin
                     state_reg <= ST_SAMP;
                  end
               end
               ST_WAIT: begin
                  scnt_reg <= 4'h0;
                  if (!enable) begin
                     state_reg <= ST_IDLE;
                  end else if (ext_rise || soft_src) begin
                     state_reg <= ST_SAMP;
                  end
               end
               ST_SAMP: begin
                  if (samp_end) begin
                     state_reg <= ST_CONV;
                     go_reg    <= 1'b1;
                  end else if (tick_reg && scnt_reg != 4'hf) begin
                     scnt_reg <= scnt_reg + 4'h1;
                  end
               end
               ST_CONV: begin
                  scnt_reg <= 4'h0;
                  if (i_conv_done) begin
                     chan_reg <= chan_next;
                     if (fin_next) begin
                        state_reg <= ST_IDLE;
                     end else if (cont_next) begin
                        state_reg <= ST_SAMP;
                     end else begin
                        state_reg <= ST_WAIT;
                     end
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // dma trigger state: set by every conversion, sequence or not
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         dma_reg <= 1'b0;
      end else if (done_now) begin
         dma_reg <= 1'b1;
      end else if (!dma_level || i_dma_ack) begin
         // edge mode drops after one cycle; level mode waits for ack
         dma_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register writes; hardware set of a flag wins over software clear
   wire tov_set = ext_rise & busy;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctl0_reg <= `ACS_CTL0_RST;
         ctl1_reg <= `ACS_CTL1_RST;
         ctl2_reg <= `ACS_CTL2_RST;
         tov_reg  <= 1'b0;
      end else begin
         if (wr_ctl0) begin
            ctl0_reg <= i_wdata;
         end
         // completion self-clears the start bit unless written to one now
         if (done_now && fin_next && !(wr_ctl0 && i_wdata[`ACS_SOFT_START])) begin
            ctl0_reg[`ACS_SOFT_START] <= 1'b0;
         end
         if (i_wr && i_addr == `ACS_ADDR_CTL1) begin
            ctl1_reg <= {1'b0, i_wdata[14:0]};
         end
         if (i_wr && i_addr == `ACS_ADDR_CTL2) begin
            ctl2_reg <= {3'h0, i_wdata[12:0]};
         end
         // write one to clear
         if (tov_set) begin
            tov_reg <= 1'b1;
         end else if (i_wr && i_addr == `ACS_ADDR_FLAG2 && i_wdata[`ACS_TOV_FLAG]) begin
            tov_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, valid the cycle after the strobe; unmapped reads zero
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_reg <= 16'h0000;
      end else if (i_rd) begin
         case (i_addr)
            `ACS_ADDR_CTL0:   rdata_reg <= ctl0_reg;
            `ACS_ADDR_CTL1:   rdata_reg <= {busy, ctl1_reg[14:0]};
            `ACS_ADDR_CTL2:   rdata_reg <= ctl2_reg;
            `ACS_ADDR_FLAG2:  rdata_reg <= {15'h0000, tov_reg};
            `ACS_ADDR_STATUS: rdata_reg <= {12'h000, chan_reg};
            default:          rdata_reg <= 16'h0000;
         endcase
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign o_rdata      = rdata_reg;
   assign o_dma_req    = dma_reg;
   assign o_busy       = busy;
   assign o_sampling   = (state_reg == ST_SAMP);
   assign o_conv_go    = go_reg;
   assign o_channel    = chan_reg;
   assign o_ref_select = ref_sel;
   assign o_power_on   = power_on;
   assign o_adc_tick   = tick_reg;

endmodule
`default_nettype wire
